// file: dv/ovrs_mcu_model.sv
// Reset input of the supervised microcontroller, with a pull-up on the line
`timescale 1ns/1ps
module ovrs_mcu_model (
  input wire logic reset_out_o,
  input wire logic reset_out_oe_n,
  output logic reset_pin,
  output logic drive_fault
);
  // A released line floats up through the pull-up
  assign reset_pin = reset_out_oe_n ? 1'b1 : reset_out_o;
  // The supervisor may only ever pull the line low
  assign drive_fault = !reset_out_oe_n && (reset_out_o !== 1'b0);
endmodule

// file: dv/tb_ovrs_top.sv
// Self-checking bench for the output voltage reset supervisor
`timescale 1ns/1ps
module tb_ovrs_top;
  import ovrs_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic en = 1'b0;
  logic ssd = 1'b0;
  logic uvb = 1'b0;
  logic uva = 1'b1;
  logic ova = 1'b0;
  logic ovb = 1'b1;
  logic [CFG_W-1:0] sel = '0;
  logic ro_o, oe_n, uv_ev, ov_ev, pin, dfault;
  logic od_bad = 1'b0;
  logic [1:0] thr_sel;
  logic [7:0] uv_pct, ov_pct;
  int error_cnt = 0;
  int n_tests = 0;
  int cyc = 0;
  int p, r, u;
  int pon_q[$], rd_q[$], sel_q[$];
  int pct_tab[4] = '{-8, -14, -25, -40};
  // Shortened delay groups, shared by the design and the bench model
  localparam int T_PON_B = 40;
  localparam int T_PON_C = 50;
  localparam int T_PON_D = 60;
  localparam int T_RD_B = 20;
  localparam int T_RD_C = 30;
  localparam int T_RD_D = 35;

  ovrs_top #(.PON_B(DLY_W'(T_PON_B)), .PON_C(DLY_W'(T_PON_C)), .PON_D(DLY_W'(T_PON_D)),
             .RD_B(DLY_W'(T_RD_B)), .RD_C(DLY_W'(T_RD_C)), .RD_D(DLY_W'(T_RD_D))) i_dut (
    .clk(clk), .sys_rst(sys_rst), .enable_pin(en), .soft_start_done(ssd),
    .delay_select_pin(sel), .uv_below_thr(uvb), .uv_above_hys(uva),
    .ov_above_thr(ova), .ov_below_hys(ovb), .reset_out_o(ro_o),
    .reset_out_oe_n(oe_n), .uv_thr_sel(thr_sel), .uv_thr_pct(uv_pct),
    .ov_thr_pct(ov_pct), .uv_event(uv_ev), .ov_event(ov_ev)
  );

  ovrs_mcu_model i_mcu (
    .reset_out_o(ro_o), .reset_out_oe_n(oe_n), .reset_pin(pin), .drive_fault(dfault)
  );

  always #50 clk = ~clk;

  always @(negedge clk) begin
    if (dfault !== 1'b0) od_bad = 1'b1;
  end

  // Cuts a hang short well past the expected run length
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      error_cnt = error_cnt + 1;
      $display("[ERR] %0t run did not finish in time", $time);
      give_verdict;
    end
  end

  task automatic give_verdict;
    $display("Mismatches %0d, comparisons %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic chk_eq(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_rng(input int got, input int lo, input int hi, input string what);
    n_tests++;
    if (got < lo || got > hi) begin
      error_cnt++;
      $display("[ERR] %0t %s: %0d cycles, expected %0d to %0d", $time, what, got, lo, hi);
    end
  endtask

  // Counts falling edges until the line reaches a level, up to a limit
  task automatic wait_pin(input logic lvl, input int lim, output int n);
    n = 0;
    while (pin !== lvl && n < lim) begin
      @(negedge clk);
      n++;
    end
  endtask

  task automatic run_code(input int c);
    int n, pc, rc, g;
    pc = pon_q[c];
    rc = rd_q[c];
    @(posedge clk);
    sel <= c[CFG_W-1:0];
    en <= 1'b1;
    tick(12);
    chk_eq({7'h0, pin}, 8'h00, "reset held before soft start");
    ssd <= 1'b1;
    wait_pin(1'b1, pc + 20, n);
    chk_rng(n, pc, pc + 4, "power-on delay");
    // Selection moves after start-up and must be ignored
    @(posedge clk);
    sel <= ~c[CFG_W-1:0];
    tick(4);
    chk_eq({6'h0, thr_sel}, 8'(sel_q[c]), "threshold select");
    chk_eq(uv_pct, 8'(pct_tab[sel_q[c]]), "threshold percent");
    chk_eq(ov_pct, 8'h07, "overvoltage threshold");
    g = 1 + $urandom_range(44);
    uvb <= 1'b1;
    uva <= 1'b0;
    tick(g);
    uvb <= 1'b0;
    uva <= 1'b1;
    wait_pin(1'b0, 60, n);
    chk_rng(n, 60, 60, "short fault ignored");
    @(posedge clk);
    uvb <= 1'b1;
    uva <= 1'b0;
    wait_pin(1'b0, 80, n);
    chk_rng(n, 51, 56, "undervoltage blanking");
    chk_eq({7'h0, uv_ev}, 8'h01, "undervoltage cause");
    chk_eq({7'h0, ov_ev}, 8'h00, "no overvoltage cause");
    @(posedge clk);
    uvb <= 1'b0;
    wait_pin(1'b1, rc + 20, n);
    chk_rng(n, rc + 20, rc + 20, "held inside undervoltage hysteresis");
    @(posedge clk);
    uva <= 1'b1;
    wait_pin(1'b1, rc + 20, n);
    chk_rng(n, rc, rc + 5, "undervoltage release delay");
    @(posedge clk);
    ova <= 1'b1;
    ovb <= 1'b0;
    wait_pin(1'b0, 80, n);
    chk_rng(n, 51, 56, "overvoltage blanking");
    chk_eq({7'h0, ov_ev}, 8'h01, "overvoltage cause");
    chk_eq({7'h0, uv_ev}, 8'h00, "undervoltage cause cleared on release");
    @(posedge clk);
    ova <= 1'b0;
    wait_pin(1'b1, rc + 20, n);
    chk_rng(n, rc + 20, rc + 20, "held inside overvoltage hysteresis");
    @(posedge clk);
    ovb <= 1'b1;
    if (rc > 100) begin
      // A fault inside the release delay must restart it from scratch
      tick(10);
      ova <= 1'b1;
      ovb <= 1'b0;
      wait_pin(1'b1, 80, n);
      chk_rng(n, 80, 80, "release delay abandoned");
      @(posedge clk);
      ova <= 1'b0;
      ovb <= 1'b1;
    end
    wait_pin(1'b1, rc + 20, n);
    chk_rng(n, rc, rc + 5, "overvoltage release delay");
    @(posedge clk);
    en <= 1'b0;
    ssd <= 1'b0;
    wait_pin(1'b0, 10, n);
    chk_rng(n, 1, 6, "reset on disable");
    tick(5);
  endtask

  initial begin
    for (int c = 0; c < 16; c++) begin
      if (c < 4) begin
        p = 600; r = 300; u = c;
      end else if (c < 8) begin
        p = T_PON_B; r = T_RD_B; u = c - 4;
      end else if (c < 11) begin
        p = T_PON_C; r = T_RD_C; u = c - 7;
      end else if (c < 13) begin
        p = T_PON_D; r = T_RD_D; u = c - 11;
      end else begin
        p = T_PON_C; r = T_RD_C; u = 0;
      end
      pon_q.push_back(p);
      rd_q.push_back(r);
      sel_q.push_back(u);
    end
    void'($urandom(32'h6580b622));
    tick(2);
    sys_rst <= 1'b0;
    tick(3);
    for (int c = 0; c < 16; c++) run_code(c);
    chk_eq({7'h0, od_bad}, 8'h00, "line never driven high");
    give_verdict;
  end
endmodule

// file: hdl/ovrs_cfg.sv
// Selection code decode and latch for delays and undervoltage threshold
`timescale 1ns/1ps
module ovrs_cfg #(
  parameter logic [ovrs_pkg::DLY_W-1:0] PON_B = ovrs_pkg::PON_B_CYC,
  parameter logic [ovrs_pkg::DLY_W-1:0] PON_C = ovrs_pkg::PON_C_CYC,
  parameter logic [ovrs_pkg::DLY_W-1:0] PON_D = ovrs_pkg::PON_D_CYC,
  parameter logic [ovrs_pkg::DLY_W-1:0] RD_B = ovrs_pkg::RD_B_CYC,
  parameter logic [ovrs_pkg::DLY_W-1:0] RD_C = ovrs_pkg::RD_C_CYC,
  parameter logic [ovrs_pkg::DLY_W-1:0] RD_D = ovrs_pkg::RD_D_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic latch,
  input wire logic [ovrs_pkg::CFG_W-1:0] code,
  output logic [ovrs_pkg::DLY_W-1:0] pon_cyc,
  output logic [ovrs_pkg::DLY_W-1:0] rd_cyc,
  output logic [1:0] uv_sel
);
  import ovrs_pkg::*;

  logic [DLY_W-1:0] pon_nxt;
  logic [DLY_W-1:0] rd_nxt;
  logic [1:0] uv_nxt;

  always_comb begin
    if (code < CFG_GRP_B) begin
      pon_nxt = PON_A_CYC; // [RULE12]
      rd_nxt = RD_A_CYC;
    end else if (code < CFG_GRP_C) begin
      pon_nxt = PON_B; // [RULE13]
      rd_nxt = RD_B;
    end else if (code < CFG_GRP_D || code >= CFG_OPEN) begin
      pon_nxt = PON_C; // [RULE14] [RULE15]
      rd_nxt = RD_C;
    end else begin
      pon_nxt = PON_D; // [RULE14]
      rd_nxt = RD_D;
    end
    case (code)
      4'h1, 4'h5, 4'h8, 4'hc: uv_nxt = UV_SEL_14;
      4'h2, 4'h6, 4'h9: uv_nxt = UV_SEL_25;
      4'h3, 4'h7, 4'ha: uv_nxt = UV_SEL_40;
      default: uv_nxt = UV_SEL_8;
    endcase
  end

  // Sampled once at initialization, held afterwards
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pon_cyc <= PON_C;
      rd_cyc <= RD_C;
      uv_sel <= UV_SEL_8;
    end else if (latch) begin // [RULE8]
      pon_cyc <= pon_nxt;
      rd_cyc <= rd_nxt;
      uv_sel <= uv_nxt;
    end
  end
endmodule

// file: hdl/ovrs_pkg.sv
// Constants, state codes and lookup values for the output voltage reset supervisor
package ovrs_pkg;

  localparam int CLK_PERIOD_NS = 100;
  localparam int DLY_W = 18;
  localparam int BLK_W = 6;
  localparam int CFG_W = 4;

  // Times as printed, in nanoseconds
  localparam int BLANK_NS = 5000;
  localparam int PON_A_NS = 60000;
  localparam int PON_B_NS = 1900000;
  localparam int PON_C_NS = 7700000;
  localparam int PON_D_NS = 15400000;
  localparam int RD_A_NS = 30000;
  localparam int RD_B_NS = 1300000;
  localparam int RD_C_NS = 5100000;
  localparam int RD_D_NS = 10200000;

  // Least times, rounded up to whole cycles
  localparam logic [BLK_W-1:0] BLANK_CYC = BLK_W'((BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [DLY_W-1:0] PON_A_CYC = DLY_W'((PON_A_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [DLY_W-1:0] PON_B_CYC = DLY_W'((PON_B_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [DLY_W-1:0] PON_C_CYC = DLY_W'((PON_C_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [DLY_W-1:0] PON_D_CYC = DLY_W'((PON_D_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [DLY_W-1:0] RD_A_CYC = DLY_W'((RD_A_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [DLY_W-1:0] RD_B_CYC = DLY_W'((RD_B_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [DLY_W-1:0] RD_C_CYC = DLY_W'((RD_C_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [DLY_W-1:0] RD_D_CYC = DLY_W'((RD_D_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Delay groups by selection code
  localparam logic [CFG_W-1:0] CFG_GRP_B = 4'h4;
  localparam logic [CFG_W-1:0] CFG_GRP_C = 4'h8;
  localparam logic [CFG_W-1:0] CFG_GRP_D = 4'hb;
  localparam logic [CFG_W-1:0] CFG_OPEN = 4'hd;

  // Undervoltage threshold selects and their percentages, and the fixed overvoltage percentage
  localparam logic [1:0] UV_SEL_8 = 2'h0;
  localparam logic [1:0] UV_SEL_14 = 2'h1;
  localparam logic [1:0] UV_SEL_25 = 2'h2;
  localparam logic [1:0] UV_SEL_40 = 2'h3;
  localparam logic [7:0] UV_PCT_8 = 8'hf8;
  localparam logic [7:0] UV_PCT_14 = 8'hf2;
  localparam logic [7:0] UV_PCT_25 = 8'he7;
  localparam logic [7:0] UV_PCT_40 = 8'hd8;
  localparam logic [7:0] OV_THR_PCT = 8'h07;

  typedef enum logic [6:0] {
    ST_OFF = 7'h01,
    ST_INIT = 7'h02,
    ST_SSTART = 7'h04,
    ST_PWRON = 7'h08,
    ST_GOOD = 7'h10,
    ST_FAULT = 7'h20,
    ST_RDLY = 7'h40
  } ovrs_state_e;

endpackage

// file: hdl/ovrs_sync.sv
// Two-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module ovrs_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          meta_r[i] <= 1'b0;
          sync_r[i] <= 1'b0;
        end else begin
          meta_r[i] <= async_in[i];
          sync_r[i] <= meta_r[i];
        end
      end
    end
  endgenerate

  assign sync_out = sync_r;
endmodule

// file: hdl/ovrs_top.sv
// Output voltage reset supervisor: blanking, delays and open-drain reset drive
`timescale 1ns/1ps
// Function
// [RULE1] Reset released only while output is in window, driven low otherwise.
// [RULE2] Reset output is open drain: pulled low or released to pull-up.
// [RULE3] Power-on delay starts at soft-start completion; release only after it.
// [RULE4] Undervoltage below selected threshold asserts reset, after blanking.
// [RULE5] Undervoltage release needs rise above threshold plus hysteresis, then delay.
// [RULE6] Overvoltage above fixed threshold asserts reset, after blanking.
// [RULE7] Overvoltage release needs fall below threshold minus hysteresis, then delay.
// [RULE8] Selection sampled once at initialization and held constant afterwards.
// [RULE9] Overvoltage threshold is fixed; selection changes only delays and undervoltage.
// [RULE10] Fault asserts reset only if it persists longer than the blanking time.
// [RULE11] Fault shorter than blanking leaves reset high; blanking restarts.
// [RULE12] Codes 0-3: 0.06 ms power-on, 0.03 ms reset delay, -8/-14/-25/-40 %.
// [RULE13] Codes 4-7: 1.9 ms power-on, 1.3 ms reset delay, -8/-14/-25/-40 %.
// [RULE14] Codes 8-10: 7.7/5.1 ms, -14/-25/-40 %; 11-12: 15.4/10.2 ms, -8/-14 %.
// [RULE15] Open setting: 7.7 ms power-on, 5.1 ms reset delay, -8 %.
// [RULE16] Overvoltage threshold sits 7 percent above nominal feedback.
// [RULE17] Reset held from enable or initialization until power-on delay expires.
// [RULE18] Fault qualified during release delay abandons it; delay restarts later.
module ovrs_top #(
  parameter logic [ovrs_pkg::DLY_W-1:0] PON_B = ovrs_pkg::PON_B_CYC,
  parameter logic [ovrs_pkg::DLY_W-1:0] PON_C = ovrs_pkg::PON_C_CYC,
  parameter logic [ovrs_pkg::DLY_W-1:0] PON_D = ovrs_pkg::PON_D_CYC,
  parameter logic [ovrs_pkg::DLY_W-1:0] RD_B = ovrs_pkg::RD_B_CYC,
  parameter logic [ovrs_pkg::DLY_W-1:0] RD_C = ovrs_pkg::RD_C_CYC,
  parameter logic [ovrs_pkg::DLY_W-1:0] RD_D = ovrs_pkg::RD_D_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic enable_pin,
  input wire logic soft_start_done,
  input wire logic [ovrs_pkg::CFG_W-1:0] delay_select_pin,
  input wire logic uv_below_thr,
  input wire logic uv_above_hys,
  input wire logic ov_above_thr,
  input wire logic ov_below_hys,
  output logic reset_out_o,
  output logic reset_out_oe_n,
  output logic [1:0] uv_thr_sel,
  output logic [7:0] uv_thr_pct,
  output logic [7:0] ov_thr_pct,
  output logic uv_event,
  output logic ov_event
);
  import ovrs_pkg::*;

  logic en_s;
  logic [CFG_W-1:0] cfg_s;
  logic uv_low_s;
  logic uv_ok_s;
  logic ov_high_s;
  logic ov_ok_s;

  ovrs_state_e state_r;
  ovrs_state_e state_nxt;

  logic [DLY_W-1:0] pon_cyc;
  logic [DLY_W-1:0] rd_cyc;
  logic [DLY_W-1:0] dly_tgt;
  logic [DLY_W-1:0] dly_cnt_r;
  logic dly_done;

  logic [BLK_W-1:0] blank_cnt_r;
  logic monitoring;
  logic fault_raw;
  logic fault_q;
  logic recov;

  logic reset_out_oe_n_r;
  logic [7:0] uv_thr_pct_r;
  logic uv_event_r;
  logic ov_event_r;

  // Pins and comparator levels cross into the clock domain
  ovrs_sync #(
    .W(CFG_W + 5)
  ) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .async_in({enable_pin, delay_select_pin, uv_below_thr, uv_above_hys,
               ov_above_thr, ov_below_hys}),
    .sync_out({en_s, cfg_s, uv_low_s, uv_ok_s, ov_high_s, ov_ok_s})
  );

  ovrs_cfg #(
    .PON_B(PON_B),
    .PON_C(PON_C),
    .PON_D(PON_D),
    .RD_B(RD_B),
    .RD_C(RD_C),
    .RD_D(RD_D)
  ) u_cfg (
    .clk(clk),
    .sys_rst(sys_rst),
    .latch(state_r == ST_INIT), // [RULE8]
    .code(cfg_s),
    .pon_cyc(pon_cyc),
    .rd_cyc(rd_cyc),
    .uv_sel(uv_thr_sel)
  );

  // Fault detection and blanking
  assign monitoring = (state_r == ST_PWRON) || (state_r == ST_GOOD) || (state_r == ST_RDLY);
  assign fault_raw = uv_low_s || ov_high_s; // [RULE4] [RULE6]
  assign fault_q = monitoring && fault_raw && (blank_cnt_r == BLANK_CYC); // [RULE10]
  assign recov = uv_ok_s && ov_ok_s; // [RULE5] [RULE7]

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      blank_cnt_r <= '0;
    end else if (!monitoring || !fault_raw) begin
      blank_cnt_r <= '0; // [RULE11]
    end else if (blank_cnt_r != BLANK_CYC) begin
      blank_cnt_r <= blank_cnt_r + 1'b1;
    end
  end

  // Delay counter restarts on every state change
  assign dly_tgt = (state_r == ST_PWRON) ? pon_cyc : rd_cyc;
  assign dly_done = (dly_cnt_r == dly_tgt - 1'b1);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dly_cnt_r <= '0;
    end else if (state_nxt != state_r) begin
      dly_cnt_r <= '0; // [RULE18]
    end else begin
      dly_cnt_r <= dly_cnt_r + 1'b1;
    end
  end

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_OFF: begin
        if (en_s) begin
          state_nxt = ST_INIT;
        end
      end
      ST_INIT: begin
        state_nxt = ST_SSTART;
      end
      ST_SSTART: begin
        if (soft_start_done) begin
          state_nxt = ST_PWRON; // [RULE3]
        end
      end
      ST_PWRON: begin
        if (fault_q) begin
          state_nxt = ST_FAULT;
        end else if (dly_done) begin
          state_nxt = ST_GOOD; // [RULE3]
        end
      end
      ST_GOOD: begin
        if (fault_q) begin
          state_nxt = ST_FAULT; // [RULE4] [RULE6]
        end
      end
      ST_FAULT: begin
        if (recov) begin
          state_nxt = ST_RDLY; // [RULE5] [RULE7]
        end
      end
      ST_RDLY: begin
        if (fault_q) begin
          state_nxt = ST_FAULT; // [RULE18]
        end else if (dly_done) begin
          state_nxt = ST_GOOD;
        end
      end
      default: begin
        state_nxt = ST_OFF;
      end
    endcase
    if (!en_s) begin
      state_nxt = ST_OFF; // [RULE17]
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r <= ST_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Open drain: pin is pulled low everywhere except the good state
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reset_out_oe_n_r <= 1'b0;
    end else begin
      reset_out_oe_n_r <= (state_nxt == ST_GOOD); // [RULE1] [RULE2] [RULE17]
    end
  end

  assign reset_out_o = 1'b0; // [RULE2]
  assign reset_out_oe_n = reset_out_oe_n_r;

  // Fault cause, held until the next release or power-down
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      uv_event_r <= 1'b0;
      ov_event_r <= 1'b0;
    end else if (state_nxt == ST_GOOD || state_nxt == ST_OFF) begin
      uv_event_r <= 1'b0;
      ov_event_r <= 1'b0;
    end else if (fault_q) begin
      uv_event_r <= uv_event_r || uv_low_s;
      ov_event_r <= ov_event_r || ov_high_s;
    end
  end

  assign uv_event = uv_event_r;
  assign ov_event = ov_event_r;

  // Threshold settings for the comparators
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      uv_thr_pct_r <= UV_PCT_8;
    end else begin
      case (uv_thr_sel)
        UV_SEL_14: uv_thr_pct_r <= UV_PCT_14;
        UV_SEL_25: uv_thr_pct_r <= UV_PCT_25;
        UV_SEL_40: uv_thr_pct_r <= UV_PCT_40;
        default: uv_thr_pct_r <= UV_PCT_8;
      endcase
    end
  end

  assign uv_thr_pct = uv_thr_pct_r;
  assign ov_thr_pct = OV_THR_PCT; // [RULE9] [RULE16]

  property p_release_src;
    @(posedge clk) disable iff (sys_rst)
    $rose(reset_out_oe_n) |-> ($past(state_r) == ST_PWRON) || ($past(state_r) == ST_RDLY);
  endproperty
  a_release_src: assert property (p_release_src) // [RULE1]
    else $error("reset released from a wrong state");

  property p_pon_len;
    @(posedge clk) disable iff (sys_rst)
    ($rose(reset_out_oe_n) && $past(state_r) == ST_PWRON)
      |-> $past(dly_cnt_r) == pon_cyc - 1'b1;
  endproperty
  a_pon_len: assert property (p_pon_len) // [RULE3]
    else $error("power-on delay length wrong");

  property p_rd_len;
    @(posedge clk) disable iff (sys_rst)
    ($rose(reset_out_oe_n) && $past(state_r) == ST_RDLY)
      |-> $past(dly_cnt_r) == rd_cyc - 1'b1;
  endproperty
  a_rd_len: assert property (p_rd_len) // [RULE5]
    else $error("reset delay length wrong");

  property p_blank;
    @(posedge clk) disable iff (sys_rst)
    ($fell(reset_out_oe_n) && en_s) |-> $past(blank_cnt_r) == BLANK_CYC && $past(fault_raw);
  endproperty
  a_blank: assert property (p_blank) // [RULE10]
    else $error("reset asserted before blanking expired");

  property p_glitch;
    @(posedge clk) disable iff (sys_rst)
    (state_r == ST_GOOD && en_s && !fault_raw) |=> reset_out_oe_n && blank_cnt_r == '0;
  endproperty
  a_glitch: assert property (p_glitch) // [RULE11]
    else $error("short fault disturbed reset");

  property p_recov;
    @(posedge clk) disable iff (sys_rst)
    (state_r == ST_FAULT && recov && en_s) |=> state_r == ST_RDLY ##1 !reset_out_oe_n;
  endproperty
  a_recov: assert property (p_recov) // [RULE7]
    else $error("recovery did not start the reset delay");

  property p_abandon;
    @(posedge clk) disable iff (sys_rst)
    (state_r == ST_RDLY && fault_q && en_s) |=> state_r == ST_FAULT && dly_cnt_r == '0;
  endproperty
  a_abandon: assert property (p_abandon) // [RULE18]
    else $error("release delay not abandoned on fault");

  property p_hold_cfg;
    @(posedge clk) disable iff (sys_rst)
    (state_r != ST_INIT) |=> $stable(uv_thr_sel) && $stable(pon_cyc) && $stable(rd_cyc);
  endproperty
  a_hold_cfg: assert property (p_hold_cfg) // [RULE8]
    else $error("configuration changed outside initialization");

  property p_startup;
    @(posedge clk) disable iff (sys_rst)
    (state_r == ST_INIT) |-> !reset_out_oe_n ##1 !reset_out_oe_n;
  endproperty
  a_startup: assert property (p_startup) // [RULE17]
    else $error("reset not held during initialization");

  property p_code0;
    @(posedge clk) disable iff (sys_rst)
    (state_r == ST_INIT && cfg_s == 4'h0) |=> pon_cyc == PON_A_CYC && rd_cyc == RD_A_CYC;
  endproperty
  a_code0: assert property (p_code0) // [RULE12]
    else $error("code 0 delays wrong");

  property p_open;
    @(posedge clk) disable iff (sys_rst)
    (state_r == ST_INIT && cfg_s >= CFG_OPEN) |=> rd_cyc == RD_C && uv_thr_sel == UV_SEL_8;
  endproperty
  a_open: assert property (p_open) // [RULE15]
    else $error("open setting wrong");

endmodule
